/* core_model.sv */
// Purpose: core bus and sequencer; Assumes: one op a call; Notes: gap after
`timescale 1ns/100ps
module core_model import page_stack_pkg::*; (
    input wire logic sys_clk,
    output sfr_req_t sfr_req,
    output irq_evt_t irq_evt
);
    initial sfr_req = '0;
    initial irq_evt = '0;
    // Released lines flip so stale values cannot pass
    task automatic op(input sfr_req_t r, input irq_evt_t e);
        @(negedge sys_clk);
        sfr_req = r;
        irq_evt = e;
        @(negedge sys_clk);
        sfr_req = '{1'b0, 1'b0, ~r.addr, ~r.wdata};
        irq_evt = '{1'b0, 1'b0, ~e.page};
    endtask : op
endmodule : core_model

/* page_props.sv */
// Purpose: page stack checks; Assumes: bound to sfr_page_stack_control; Notes: index unseen
`timescale 1ns/100ps
module page_props import page_stack_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_rvalid,
    input wire logic sfr_hit,
    input wire irq_evt_t irq_evt,
    input wire logic [7:0] current_page,
    input wire logic auto_paging_enable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic cf;
    assign cf = sfr_req.addr == PAGE_CONTROL_ADDR;
    property p_hit;
        sfr_req.rd && cf |=> sfr_rvalid && sfr_hit;
    endproperty
    a_hit: assert property (p_hit) else $error("no read answer");
    property p_miss;
        sfr_req.rd && current_page != STACK_VIEW_PAGE
            && sfr_req.addr == STACK_VIEW_ADDR |=> !sfr_rvalid;
    endproperty
    a_miss: assert property (p_miss) else $error("miss");
    property p_rdcf;
        sfr_req.rd && cf |=> sfr_rdata[3:1] == 0 && !sfr_rdata[7];
    endproperty
    a_rdcf: assert property (p_rdcf) else $error("reserved bits set");
    property p_wr;
        sfr_req.wr && cf |=> auto_paging_enable == $past(sfr_req.wdata[0]);
    endproperty
    a_wr: assert property (p_wr) else $error("enable write");
    property p_entry;
        irq_evt.entry && auto_paging_enable
            |=> current_page == $past(irq_evt.page);
    endproperty
    a_entry: assert property (p_entry) else $error("entry page");
    property p_off;
        !auto_paging_enable && !(sfr_req.wr && cf) |=> $stable(current_page);
    endproperty
    a_off: assert property (p_off) else $error("page moved");
    property p_pop;
        irq_evt.entry && auto_paging_enable ##1
            !irq_evt.entry && !irq_evt.exit ##1
            irq_evt.exit && !irq_evt.entry && auto_paging_enable
            |=> current_page == $past(current_page, 3);
    endproperty
    a_pop: assert property (p_pop) else $error("pop");
    property p_rst;
        disable iff (1'b0) !rst_n |=> auto_paging_enable && current_page == 0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset");
    property p_nohit;
        sfr_req.rd && !cf && sfr_req.addr != STACK_VIEW_ADDR |=> !sfr_hit;
    endproperty
    a_nohit: assert property (p_nohit) else $error("stray hit");
endmodule : page_props
bind sfr_page_stack_control page_props page_props_inst (.*);

/* page_stack_pkg.sv */
// Purpose: constants and types for the SFR page stack control block
// Assumes: 8-bit SFR bus from the core, single clock domain
// Notes: register addresses are SFR direct addresses
// What this block does
// - Control register decoded at 0xCF, every page.
// - Index field bits 6:4 selects viewed level.
// - Index 0 top, 1..4 lower; 5..7 invalid.
// - Enabled interrupt entry pushes current page.
// - Enabled entry loads the interrupt source page.
// - Enabled return pops stack into current page.
// - Disabled: no push, pop or page change.
// - Push shifts levels down, then loads page.
// - Pop moves level one up, shifts rest up.
// - Auto paging enabled after every reset.
// - Stack view read-only at 0xD3, page F.
package page_stack_pkg;
    localparam logic [7:0] PAGE_CONTROL_ADDR = 8'h00_CF;
    localparam logic [7:0] STACK_VIEW_ADDR = 8'h00_D3;
    localparam logic [7:0] STACK_VIEW_PAGE = 8'h00_0F;
    localparam logic [7:0] PAGE_CONTROL_RESET = 8'h00_01;
    localparam logic [7:0] CURRENT_PAGE_RESET = 8'h00_00;
    localparam logic [7:0] PAGE_CONTROL_MASK = 8'h00_71;
    localparam int ENABLE_BIT = 0;
    localparam int INDEX_LSB = 4;
    localparam int LEVELS = 4;
    localparam logic [2:0] INDEX_BOTTOM = 3'h4;

    typedef logic [7:0] page_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic entry;
        logic exit;
        page_t page;
    } irq_evt_t;

    typedef struct packed {
        page_t page_control;
        page_t current_page;
        page_t [LEVELS-1:0] level;
        page_t rdata;
        logic rvalid;
        logic hit;
    } state_t;
endpackage : page_stack_pkg

/* sfr_page_stack_control.sv */
// Purpose: page control register, five-level page stack, stack view
// Assumes: core issues one-cycle strobes; entry and exit never coincide
// Notes: read data is registered, valid one cycle after the read strobe
`timescale 1ns/100ps
module sfr_page_stack_control (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // SFR bus
    input wire page_stack_pkg::sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_rvalid,
    output logic sfr_hit,
    // Interrupt sequencer
    input wire page_stack_pkg::irq_evt_t irq_evt,
    // Page state
    output logic [7:0] current_page,
    output logic auto_paging_enable
);
    import page_stack_pkg::*;

    // Width of the index field follows its bottom code
    typedef logic [$bits(INDEX_BOTTOM)-1:0] index_t;

    // Selector of one of the levels below the stack top
    typedef logic [$clog2(LEVELS)-1:0] level_sel_t;

    // Value of the whole block state after any reset
    localparam state_t ST_RESET = '{
        page_control: PAGE_CONTROL_RESET,
        current_page: CURRENT_PAGE_RESET,
        level: '0,
        rdata: '0,
        rvalid: 1'b0,
        hit: 1'b0
    };

    // Index one names the first level below the top
    localparam index_t INDEX_TOP = '0;
    localparam index_t INDEX_STEP = index_t'(1);

    state_t st_r;
    state_t st_nxt;

    // Control register ignores the page: it is visible on every page
    function automatic logic ctrl_addr_hit(input sfr_req_t r);
        logic h;
        h = (r.addr == PAGE_CONTROL_ADDR);
        return h;
    endfunction : ctrl_addr_hit

    // Stack view shares its address with other registers on other pages
    function automatic logic view_addr_hit(input sfr_req_t r,
                                           input page_t page);
        logic h;
        h = 1'b0;
        if (r.addr == STACK_VIEW_ADDR) begin
            h = (page == STACK_VIEW_PAGE);
        end
        return h;
    endfunction : view_addr_hit

    function automatic index_t stack_index(input page_t ctrl);
        index_t i;
        i = ctrl[INDEX_LSB +: $bits(index_t)];
        return i;
    endfunction : stack_index

    function automatic logic paging_on(input page_t ctrl);
        logic en;
        en = ctrl[ENABLE_BIT];
        return en;
    endfunction : paging_on

    // Reserved bits never store, so they always read back as zero
    function automatic page_t ctrl_write_value(input page_t wdata);
        page_t v;
        v = wdata & PAGE_CONTROL_MASK;
        return v;
    endfunction : ctrl_write_value

    // Invalid codes read as zero rather than aliasing a real level
    function automatic page_t view_level(input state_t s, input index_t i);
        page_t v;
        level_sel_t sel;
        v = '0;
        sel = level_sel_t'(i - INDEX_STEP);
        if (i == INDEX_TOP) begin
            v = s.current_page;
        end else if (i <= INDEX_BOTTOM) begin
            v = s.level[sel];
        end
        return v;
    endfunction : view_level

    // Push: every level moves one down, the bottom value falls off
    function automatic state_t push_stack(input state_t s, input page_t p);
        state_t n;
        n = s;
        for (int k = LEVELS - 1; k > 0; k--) begin
            n.level[k] = s.level[k-1];
        end
        n.level[0] = s.current_page;
        n.current_page = p;
        return n;
    endfunction : push_stack

    // Pop: the bottom keeps its value, so an over-deep return repeats it
    function automatic state_t pop_stack(input state_t s);
        state_t n;
        n = s;
        n.current_page = s.level[0];
        for (int k = 0; k < LEVELS - 1; k++) begin
            n.level[k] = s.level[k+1];
        end
        return n;
    endfunction : pop_stack

    // Read answer uses pre-edge values, so a same-cycle write is not seen
    function automatic state_t read_answer(input state_t n,
                                           input state_t s,
                                           input sfr_req_t r);
        state_t a;
        a = n;
        if (r.rd) begin
            if (ctrl_addr_hit(r)) begin
                a.rdata = s.page_control;
                a.rvalid = 1'b1;
                a.hit = 1'b1;
            end else if (view_addr_hit(r, s.current_page)) begin
                a.rdata = view_level(s, stack_index(s.page_control));
                a.rvalid = 1'b1;
                a.hit = 1'b1;
            end
        end
        return a;
    endfunction : read_answer

    // Entry wins when the sequencer raises both events together
    function automatic state_t apply_events(input state_t n,
                                            input state_t s,
                                            input irq_evt_t e);
        state_t a;
        a = n;
        if (paging_on(s.page_control)) begin
            if (e.entry) begin
                a = push_stack(n, e.page);
            end else if (e.exit) begin
                a = pop_stack(n);
            end
        end
        return a;
    endfunction : apply_events

    always_comb begin
        st_nxt = st_r;
        // Answer strobes last one cycle only
        st_nxt.rvalid = 1'b0;
        st_nxt.hit = 1'b0;
        st_nxt = read_answer(st_nxt, st_r, sfr_req);
        if (sfr_req.wr) begin
            if (ctrl_addr_hit(sfr_req)) begin
                st_nxt.page_control = ctrl_write_value(sfr_req.wdata);
            end
        end
        // Writes to the stack view address are refused: it is read-only
        st_nxt = apply_events(st_nxt, st_r, irq_evt);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // All outputs come straight from the state register
    assign sfr_rdata = st_r.rdata;
    assign sfr_rvalid = st_r.rvalid;
    assign sfr_hit = st_r.hit;
    assign current_page = st_r.current_page;
    assign auto_paging_enable = paging_on(st_r.page_control);
endmodule : sfr_page_stack_control

/* tb_sfr_page_stack_control.sv */
// Purpose: bench; Assumes: core_model drives; Notes: view needs page F
`timescale 1ns/100ps
module tb_sfr_page_stack_control;
    import page_stack_pkg::*;
    logic sys_clk = 0;
    logic rst_n = 0;
    sfr_req_t q;
    irq_evt_t e;
    logic [7:0] rd, cp;
    logic rv, hit, ape;
    int n_mismatch = 0;
    int checks_done = 0;
    always #20 sys_clk = ~sys_clk;
    core_model core_model_inst (.sys_clk, .sfr_req(q), .irq_evt(e));
    sfr_page_stack_control sfr_page_stack_control_inst (.sys_clk, .rst_n,
        .sfr_req(q), .sfr_rdata(rd), .sfr_rvalid(rv), .sfr_hit(hit),
        .irq_evt(e), .current_page(cp), .auto_paging_enable(ape));
    task chk(input logic [7:0] s, x);
        checks_done++;
        if (s !== x) begin
            n_mismatch++;
            $display("mismatch %0t got %h want %h", $time, s, x);
        end
    endtask : chk
    task rdc(input logic [7:0] a, x, input logic v);
        core_model_inst.op('{1'b0, 1'b1, a, 8'h00}, '0);
        chk({7'h0, rv}, {7'h0, v});
        chk({7'h0, hit}, {7'h0, v});
        if (v) chk(rd, x);
    endtask : rdc
    task wrc(input logic [7:0] d);
        core_model_inst.op('{1'b1, 1'b0, PAGE_CONTROL_ADDR, d}, '0);
    endtask : wrc
    task ev(input logic n, input logic [7:0] p);
        core_model_inst.op('0, '{n, !n, p});
    endtask : ev
    task stop_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    task t_reset;
        rdc(PAGE_CONTROL_ADDR, 8'h01, 1);
        chk({7'h0, ape}, 8'h01);
        chk(cp, 8'h00);
    endtask : t_reset
    task t_mask;
        wrc(8'hFF);
        rdc(PAGE_CONTROL_ADDR, 8'h71, 1);
    endtask : t_mask
    task t_push_view;
        for (int i = 1; i < 5; i++) ev(1, 8'(i));
        ev(1, 8'h0F);
        chk(cp, 8'h0F);
        for (int i = 0; i < 6; i++) begin
            wrc(8'(i * 16 + 1));
            rdc(STACK_VIEW_ADDR, i > 4 ? 8'h0 : i ? 8'(5 - i) : 8'h0F, 1);
        end
    endtask : t_push_view
    task t_pop;
        for (int i = 4; i > 1; i--) begin
            ev(0, 8'h00);
            chk(cp, 8'(i));
        end
        rdc(STACK_VIEW_ADDR, 8'h00, 0);
    endtask : t_pop
    task t_nest;
        ev(1, 8'h09);
        chk(cp, 8'h09);
        ev(0, 8'h00);
        chk(cp, 8'h02);
    endtask : t_nest
    task t_disable;
        wrc(8'h00);
        chk({7'h0, ape}, 8'h00);
        ev(1, 8'h09);
        chk(cp, 8'h02);
        ev(0, 8'h00);
        chk(cp, 8'h02);
    endtask : t_disable
    task t_rerst;
        @(negedge sys_clk);
        rst_n = 0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1;
        chk({7'h0, ape}, 8'h01);
        chk(cp, 8'h00);
        rdc(PAGE_CONTROL_ADDR, 8'h01, 1);
    endtask : t_rerst
    initial begin
        repeat (5) @(negedge sys_clk);
        rst_n = 1;
        t_reset;
        t_mask;
        t_push_view;
        t_pop;
        t_nest;
        t_disable;
        t_rerst;
        stop_test;
    end
    initial begin
        #100000;
        n_mismatch++;
        stop_test;
    end
endmodule : tb_sfr_page_stack_control
